// ==== design/pdw_bridge_leg.sv ====
// bridge leg: registers both ends of one phase and inserts dead time
`timescale 1ns/100ps
`default_nettype none
module pdw_bridge_leg (
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  input  wire logic       i_drive,
  input  wire logic       i_wave,
  input  wire logic       i_full,
  input  wire logic [3:0] i_dead,
  output logic            o_a,
  output logic            o_b
);
  import pdw_pkg::*;

  logic       prev_q;
  logic [3:0] stable_q;
  logic       settled;

  // the edge clock itself never counts as settled, else the stale count lets an end switch with no gap
  assign settled = (i_wave == prev_q) && (stable_q >= i_dead);

  // clocks since the last wave edge, saturating
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      prev_q   <= 1'b0;
      stable_q <= '0;
    end else begin
      prev_q <= i_wave;
      if (i_wave != prev_q) begin
        stable_q <= '0;
      end else if (stable_q != 4'hF) begin
        stable_q <= stable_q + 4'h1;
      end
    end
  end

  // end b stays grounded in half bridge; both ends low while not driving
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_a <= 1'b0;
      o_b <= 1'b0;
    end else begin
      o_a <= i_drive && i_wave && settled;
      o_b <= i_drive && i_full && !i_wave && settled;
    end
  end
endmodule : pdw_bridge_leg
`default_nettype wire

// ==== design/pdw_period_timer.sv ====
// period timer: counts master clocks and marks each switching period boundary
`timescale 1ns/100ps
`default_nettype none
module pdw_period_timer #(
  parameter int PER_W = 10
) (
  input  wire logic             i_mclk,
  input  wire logic             i_rst,
  input  wire logic             i_run,
  input  wire logic [PER_W-1:0] i_len,
  pdw_wave_if.timer             wave
);
  import pdw_pkg::*;

  logic [PER_W-1:0] cnt_q;
  logic [PER_W-1:0] len_q;
  logic [PER_W-1:0] last;

  // a length below two would leave no room for a high and a low part
  assign last = (len_q < PER_W'(2)) ? PER_W'(1) : len_q - PER_W'(1);

  // ------------------------------------------------------------------
  // position counter; new length taken at a boundary, and on every clock while stopped
  // ------------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= '0;
      len_q <= '0;
    end else if (!i_run) begin
      cnt_q <= '0;
      len_q <= i_len;
    end else if (cnt_q >= last) begin
      cnt_q <= '0;
      len_q <= i_len;
    end else begin
      cnt_q <= cnt_q + PER_W'(1);
    end
  end

  assign wave.pos      = cnt_q;
  assign wave.len      = len_q;
  assign wave.boundary = i_run && (cnt_q == '0);
endmodule : pdw_period_timer
`default_nettype wire

// ==== design/pdw_piezo_drive.sv ====
// top: register file, pulse counter, phase and duty shaping of the two-phase piezo drive
`timescale 1ns/100ps
`default_nettype none
// Operation
// - every write of the pulse count restarts counting of generated pulses
// - a zero pulse count stops drive at once and pulls all phase outputs low
// - power-down halts pulses immediately and grounds all phase outputs; cal mode shows reset value 01
// - bit 6 of the pulse count high byte is direction; it swaps leading phase
// - pulse count is eleven bits, 0 to 2047; upper five bits ignored
// - duty setting resets to zero at power-up and during power-down
// - duty setting zero gives half-period high time on each phase
// - nonzero duty setting gives high time of that many master clocks
// - phase shift resets to zero; zero gives a quarter-period shift
// - nonzero phase shift delays second phase by that many master clocks
// - three-bit period offset is added to period count, lowering frequency
// - offset applies only while tracking and calibration are inactive
// - offset zero leaves frequency unchanged; register resets to zero
// - offset register bits 7..4: idle, half bridge, mixed bridge, long dead time
// - idle mode cuts drive power and keeps calibration state
// - mix ratio 0 means all half bridge, 128 all full bridge
// - full-bridge pulse fraction equals mix ratio divided by 128
// - count decrements once per pulse; generation stops at zero
// - switching period is the nine-bit period count in master clocks
// - two square-wave phases are driven; the leading one sets direction
module pdw_piezo_drive #(
  parameter int CNT_W = 11,
  parameter int PER_W = 10
) (
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  input  wire logic       i_power_down_pin_n,
  input  wire logic       i_wr_en,
  input  wire logic [7:0] i_wr_addr,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_tracking_active,
  output logic      [1:0] o_phase_a,
  output logic      [1:0] o_phase_b,
  output logic            o_motor_active,
  output logic            o_idle_mode,
  output logic      [1:0] o_cal_mode
);
  import pdw_pkg::*;

  // ------------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------------
  logic [7:0]       control_q;
  logic [7:0]       period_lo_q;
  logic [7:0]       pulse_hi_q;
  logic [7:0]       pulse_lo_q;
  logic [7:0]       duty_cycle_setting_q;
  logic [7:0]       inter_phase_delay_setting_q;
  logic [7:0]       frequency_offset_and_modes_q;
  logic [7:0]       bridge_mix_ratio_q;

  // ------------------------------------------------------------------
  // decoded controls
  // ------------------------------------------------------------------
  logic             wr_pulse_lo;
  logic [CNT_W-1:0] count_written;
  logic             dir_bit;
  logic [1:0]       ds_sel;
  logic             idle_enable_bit;
  logic             half_bridge_enable_bit;
  logic             mixed_bridge_enable_bit;
  logic             long_dead_time_enable_bit;
  logic [8:0]       period_count;
  logic             offset_allowed;
  logic [PER_W-1:0] period_len;
  logic [3:0]       dead_cyc;

  // ------------------------------------------------------------------
  // pulse and drive state
  // ------------------------------------------------------------------
  pdw_state_t       state_q;
  pdw_state_t       state_d;
  logic [CNT_W-1:0] remain_q;
  logic             pulse_on_q;
  logic             full_q;
  logic [7:0]       mix_acc_q;
  logic             take_pulse;
  logic             active_now;
  logic             full_now;
  logic [8:0]       mix_sum;
  logic             mix_full;
  logic [7:0]       mix_eff;

  // ------------------------------------------------------------------
  // waveform shaping
  // ------------------------------------------------------------------
  logic [PER_W-1:0] high_len;
  logic [PER_W-1:0] shift_len;
  logic [PER_W-1:0] pos_b;
  logic             wave_lead;
  logic             wave_lag;
  logic [1:0]       wave;
  logic [1:0]       leg_en;

  pdw_wave_if #(.PER_W(PER_W)) wave_bus ();

  // ------------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------------
  assign wr_pulse_lo = i_wr_en && (i_wr_addr == ADDR_PULSE_LO);

  // power-down pin acts as a synchronous clear of every setting
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      control_q                    <= CONTROL_RST;
      period_lo_q                  <= PERIOD_RST;
      duty_cycle_setting_q         <= DUTY_RST;
      inter_phase_delay_setting_q  <= PHASE_RST;
      frequency_offset_and_modes_q <= OFFSET_RST;
      bridge_mix_ratio_q           <= MIX_RST;
    end else if (!i_power_down_pin_n) begin
      control_q                    <= CONTROL_RST;
      period_lo_q                  <= PERIOD_RST;
      duty_cycle_setting_q         <= DUTY_RST;
      inter_phase_delay_setting_q  <= PHASE_RST;
      frequency_offset_and_modes_q <= OFFSET_RST;
      bridge_mix_ratio_q           <= MIX_RST;
    end else if (i_wr_en) begin
      case (i_wr_addr)
        ADDR_CONTROL: control_q                    <= i_wr_data;
        ADDR_PERIOD:  period_lo_q                  <= i_wr_data;
        ADDR_DUTY:    duty_cycle_setting_q         <= i_wr_data;
        ADDR_PHASE:   inter_phase_delay_setting_q  <= i_wr_data;
        ADDR_OFFSET:  frequency_offset_and_modes_q <= i_wr_data;
        ADDR_MIX:     bridge_mix_ratio_q           <= i_wr_data;
        default:      ;
      endcase
    end
  end

  // pulse count bytes; the high byte also carries period msb and direction
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pulse_hi_q <= PULSE_RST;
      pulse_lo_q <= PULSE_RST;
    end else if (!i_power_down_pin_n) begin
      pulse_hi_q <= PULSE_RST;
      pulse_lo_q <= PULSE_RST;
    end else if (i_wr_en && (i_wr_addr == ADDR_PULSE_HI)) begin
      pulse_hi_q <= i_wr_data;
    end else if (wr_pulse_lo) begin
      pulse_lo_q <= i_wr_data;
    end
  end

  // ------------------------------------------------------------------
  // field decode
  // ------------------------------------------------------------------
  // count commits on the low byte so a two-byte write is never half taken
  assign count_written = {pulse_hi_q[PHI_COUNT_MSB:0], i_wr_data};
  assign dir_bit       = pulse_hi_q[PHI_DIR_BIT];
  assign ds_sel        = pulse_hi_q[PHI_DS_MSB:PHI_DS_LSB];

  assign idle_enable_bit           = frequency_offset_and_modes_q[MODE_IDLE_BIT];
  assign half_bridge_enable_bit    = frequency_offset_and_modes_q[MODE_HALF_BIT];
  assign mixed_bridge_enable_bit   = frequency_offset_and_modes_q[MODE_MIX_BIT];
  assign long_dead_time_enable_bit = frequency_offset_and_modes_q[MODE_LONG_DT];

  // ------------------------------------------------------------------
  // period length
  // ------------------------------------------------------------------
  assign period_count   = {pulse_hi_q[PHI_PERIOD_MSB], period_lo_q};
  assign offset_allowed = !i_tracking_active
                          && (control_q[CTRL_CAL_MSB:CTRL_CAL_LSB] == 2'b00);
  // offset only lengthens the period, so frequency can only go down
  assign period_len = PER_W'(period_count)
                      + (offset_allowed
                         ? PER_W'(frequency_offset_and_modes_q[OFFSET_MSB:0])
                         : PER_W'(0));

  // dead time: selection bits only count with long dead time on
  assign dead_cyc = long_dead_time_enable_bit
                    ? (DEAD_STEP * {2'b00, ds_sel}) + DEAD_STEP
                    : DEAD_STD_CYC;

  // ------------------------------------------------------------------
  // drive state
  // ------------------------------------------------------------------
  always_comb begin
    state_d = ST_OFF;
    case (state_q)
      ST_OFF, ST_RUN, ST_IDLE: begin
        if (!i_power_down_pin_n) begin
          state_d = ST_OFF;
        end else if (idle_enable_bit) begin
          state_d = ST_IDLE;
        end else if (wr_pulse_lo && (count_written == '0)) begin
          state_d = ST_OFF;
        end else if (wr_pulse_lo || (remain_q != '0) || pulse_on_q) begin
          state_d = ST_RUN;
        end else begin
          state_d = ST_OFF;
        end
      end
      default: state_d = ST_OFF;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // ------------------------------------------------------------------
  // period timer
  // ------------------------------------------------------------------
  pdw_period_timer #(.PER_W(PER_W)) u_timer (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .i_run  (state_q == ST_RUN),
    .i_len  (period_len),
    .wave   (wave_bus.timer)
  );

  // ------------------------------------------------------------------
  // pulse counter
  // ------------------------------------------------------------------
  assign take_pulse = wave_bus.boundary && (remain_q != '0);

  // a new write always wins over a decrement in the same clock
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      remain_q <= '0;
    end else if (!i_power_down_pin_n) begin
      remain_q <= '0;
    end else if (wr_pulse_lo) begin
      remain_q <= count_written;
    end else if (take_pulse && (state_q == ST_RUN)) begin
      remain_q <= remain_q - CNT_W'(1);
    end
  end

  // one pulse lasts exactly one switching period
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pulse_on_q <= 1'b0;
    end else if (!i_power_down_pin_n || (state_d != ST_RUN)) begin
      pulse_on_q <= 1'b0;
    end else if (wave_bus.boundary) begin
      pulse_on_q <= take_pulse;
    end
  end

  // ------------------------------------------------------------------
  // mixed bridge selection
  // ------------------------------------------------------------------
  // values above full are treated as full
  assign mix_eff  = (bridge_mix_ratio_q > MIX_FULL) ? MIX_FULL : bridge_mix_ratio_q;
  assign mix_sum  = {1'b0, mix_acc_q} + {1'b0, mix_eff};
  assign mix_full = (mix_sum >= {1'b0, MIX_FULL});

  // error accumulator spreads full pulses evenly, e.g. 32 gives one in four
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      mix_acc_q <= '0;
    end else if (!i_power_down_pin_n) begin
      mix_acc_q <= '0;
    end else if (take_pulse && mixed_bridge_enable_bit) begin
      mix_acc_q <= mix_full ? 8'(mix_sum - {1'b0, MIX_FULL}) : mix_sum[7:0];
    end
  end

  // bridge style of the pulse starting at this boundary
  always_comb begin
    if (mixed_bridge_enable_bit) begin
      full_now = mix_full;
    end else begin
      full_now = !half_bridge_enable_bit;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      full_q <= 1'b1;
    end else if (take_pulse) begin
      full_q <= full_now;
    end
  end

  // ------------------------------------------------------------------
  // phase and duty shaping
  // ------------------------------------------------------------------
  // at the boundary clock the new pulse decision is used directly
  assign active_now = (state_q == ST_RUN)
                      && (wave_bus.boundary ? take_pulse : pulse_on_q)
                      && (state_d == ST_RUN);

  assign high_len  = (duty_cycle_setting_q == '0)
                     ? (wave_bus.len >> 1)
                     : PER_W'(duty_cycle_setting_q);
  assign shift_len = (inter_phase_delay_setting_q == '0)
                     ? (wave_bus.len >> 2)
                     : PER_W'(inter_phase_delay_setting_q);

  // position of the delayed phase, wrapped into the period
  assign pos_b = (wave_bus.pos >= shift_len)
                 ? wave_bus.pos - shift_len
                 : wave_bus.pos + wave_bus.len - shift_len;

  assign wave_lead = (wave_bus.pos < high_len);
  assign wave_lag  = (pos_b < high_len);

  // direction picks which output phase leads
  assign wave[0] = dir_bit ? wave_lag : wave_lead;
  assign wave[1] = dir_bit ? wave_lead : wave_lag;

  assign leg_en[0] = active_now && control_q[CTRL_PH1_EN_BIT];
  assign leg_en[1] = active_now && control_q[CTRL_PH2_EN_BIT];

  // ------------------------------------------------------------------
  // output legs
  // ------------------------------------------------------------------
  // dead time is applied per leg so each phase switches cleanly on its own edges
  for (genvar g = 0; g < 2; g++) begin : g_leg
    pdw_bridge_leg u_leg (
      .i_mclk  (i_mclk),
      .i_rst   (i_rst),
      .i_drive (leg_en[g]),
      .i_wave  (wave[g]),
      .i_full  (wave_bus.boundary ? full_now : full_q),
      .i_dead  (dead_cyc),
      .o_a     (o_phase_a[g]),
      .o_b     (o_phase_b[g])
    );
  end

  // ------------------------------------------------------------------
  // status outputs
  // ------------------------------------------------------------------
  // idle keeps all settings, only the drive stops
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_motor_active <= 1'b0;
      o_idle_mode    <= 1'b0;
      o_cal_mode     <= 2'b00;
    end else begin
      o_motor_active <= active_now;
      o_idle_mode    <= i_power_down_pin_n && idle_enable_bit;
      o_cal_mode     <= control_q[CTRL_CAL_MSB:CTRL_CAL_LSB];
    end
  end

endmodule : pdw_piezo_drive
`default_nettype wire

// ==== design/pdw_pkg.sv ====
// package: register map, field layout, reset values and states of the piezo waveform control
package pdw_pkg;

  // ------------------------------------------------------------------
  // register offsets (byte-wide write-only registers)
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL  = 8'h00;
  localparam logic [7:0] ADDR_PERIOD   = 8'h01;
  localparam logic [7:0] ADDR_PULSE_HI = 8'h02;
  localparam logic [7:0] ADDR_PULSE_LO = 8'h03;
  localparam logic [7:0] ADDR_DUTY     = 8'h04;
  localparam logic [7:0] ADDR_PHASE    = 8'h05;
  localparam logic [7:0] ADDR_OFFSET   = 8'h06;
  localparam logic [7:0] ADDR_MIX      = 8'h07;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int CTRL_CAL_MSB    = 3;
  localparam int CTRL_CAL_LSB    = 2;
  localparam int CTRL_PH1_EN_BIT = 1;
  localparam int CTRL_PH2_EN_BIT = 0;
  localparam int PHI_PERIOD_MSB  = 7;
  localparam int PHI_DIR_BIT     = 6;
  localparam int PHI_DS_MSB      = 5;
  localparam int PHI_DS_LSB      = 4;
  localparam int PHI_COUNT_MSB   = 2;
  localparam int MODE_IDLE_BIT   = 7;
  localparam int MODE_HALF_BIT   = 6;
  localparam int MODE_MIX_BIT    = 5;
  localparam int MODE_LONG_DT    = 4;
  localparam int OFFSET_MSB      = 2;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] CONTROL_RST = 8'h67;
  localparam logic [7:0] PERIOD_RST  = 8'h7D;
  localparam logic [7:0] PULSE_RST   = 8'h00;
  localparam logic [7:0] DUTY_RST    = 8'h00;
  localparam logic [7:0] PHASE_RST   = 8'h00;
  localparam logic [7:0] OFFSET_RST  = 8'h00;
  localparam logic [7:0] MIX_RST     = 8'h80;

  // ------------------------------------------------------------------
  // counts
  // ------------------------------------------------------------------
  localparam logic [7:0] MIX_FULL     = 8'h80;  // all pulses full bridge
  localparam logic [3:0] DEAD_STD_CYC = 4'h1;   // dead time with long dead time off
  localparam logic [3:0] DEAD_STEP    = 4'h2;   // long dead time: 2,4,6,8 clocks

  // drive state, one-hot
  typedef enum logic [2:0] {
    ST_OFF  = 3'b001,
    ST_RUN  = 3'b010,
    ST_IDLE = 3'b100
  } pdw_state_t;

endpackage : pdw_pkg

// ==== design/pdw_wave_if.sv ====
// interface: period position and boundary strobe from the period timer
`timescale 1ns/100ps
`default_nettype none
interface pdw_wave_if #(parameter int PER_W = 10);
  logic [PER_W-1:0] pos;       // clock position inside the current period
  logic [PER_W-1:0] len;       // length of the current period in clocks
  logic             boundary;  // first clock of a period

  modport timer (output pos, output len, output boundary);
  modport user  (input pos, input len, input boundary);
endinterface : pdw_wave_if
`default_nettype wire

// ==== verification/pdw_motor_model.sv ====
// motor model: tallies pulses and times the edges seen at the two bridge phases
`timescale 1ns/100ps
`default_nettype none
module pdw_motor_model (
  input  wire logic        i_mclk,
  input  wire logic        i_clr,
  input  wire logic [1:0]  i_a,
  input  wire logic [1:0]  i_b,
  output logic      [15:0] o_pulses,
  output logic      [15:0] o_full,
  output logic      [15:0] o_per,
  output logic      [15:0] o_hi,
  output logic      [15:0] o_sh
);
  logic [15:0] t_q = 16'h0000;  // free clock count
  logic [15:0] r_q = 16'h0000;  // time of the last phase 1 rise
  logic [3:0]  ab_q = 4'h0;
  // a passive load: it only watches edges, so all times are taken from phase 1 rises
  always_ff @(posedge i_mclk) begin
    t_q <= t_q + 16'h0001;
    ab_q <= {i_a, i_b};
    if (i_a[0] && !ab_q[2]) begin
      o_per <= t_q - r_q;
      r_q <= t_q;
    end
    if (!i_a[0] && ab_q[2]) o_hi <= t_q - r_q;
    if (i_a[1] && !ab_q[3]) o_sh <= t_q - r_q;
    o_pulses <= i_clr ? 16'h0000 : o_pulses + 16'(i_a[0] && !ab_q[2]);
    o_full <= i_clr ? 16'h0000 : o_full + 16'(i_b[0] && !ab_q[0]);
  end
endmodule : pdw_motor_model
`default_nettype wire

// ==== verification/pdw_piezo_drive_props.sv ====
// checker: port timing relations of the piezo drive, bound into its top
`timescale 1ns/100ps
`default_nettype none
module pdw_piezo_drive_props (
  input wire logic       i_mclk,
  input wire logic       i_rst,
  input wire logic       i_power_down_pin_n,
  input wire logic       i_wr_en,
  input wire logic [7:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic [1:0] o_phase_a,
  input wire logic [1:0] o_phase_b,
  input wire logic       o_motor_active,
  input wire logic       o_idle_mode
);
  import pdw_pkg::*;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // count bits of the high byte, so a zero count can be told apart; power-down clears them
  logic [2:0] hi_q;
  wire        pd   = i_power_down_pin_n;
  wire        lo   = i_wr_en && pd && i_wr_addr == ADDR_PULSE_LO;
  wire        zero = {hi_q, i_wr_data} == 11'h000;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) hi_q <= 3'h0;
    else if (!pd) hi_q <= 3'h0;
    else if (i_wr_en && i_wr_addr == ADDR_PULSE_HI) hi_q <= i_wr_data[2:0];
  end
  // the legs fall in the same clock as the drive state and the active flag, yet the wait on them is longer
  a_zero_stops: assert property (lo && zero ##1 pd |-> ##1 !o_motor_active)
    else $error("drive kept after zero count");
  a_zero_legs: assert property (lo && zero ##1 pd [*4] |-> (o_phase_a | o_phase_b) == 2'h0)
    else $error("legs high after zero count");
  a_count_starts: assert property (lo && !zero && !o_idle_mode ##1 pd |-> ##1 o_motor_active)
    else $error("count write did not start drive");
  a_pd_quiet: assert property (!pd [*3] |-> !o_motor_active && (o_phase_a | o_phase_b) == 2'h0)
    else $error("outputs driven in power-down");
  a_pd_no_idle: assert property (!pd [*2] |-> !o_idle_mode) else $error("idle shown in power-down");
  a_idle_on: assert property (i_wr_en && pd && i_wr_addr == ADDR_OFFSET && i_wr_data[MODE_IDLE_BIT] ##1 pd
    |-> ##[0:1] o_idle_mode) else $error("idle bit not shown");
  a_idle_halts: assert property (o_idle_mode [*3] |-> !o_motor_active) else $error("drive in idle");
  a_legs_apart: assert property ((o_phase_a & o_phase_b) == 2'h0) else $error("both ends of a leg high");
endmodule : pdw_piezo_drive_props
bind pdw_piezo_drive pdw_piezo_drive_props u_props (.i_mclk, .i_rst, .i_power_down_pin_n, .i_wr_en,
  .i_wr_addr, .i_wr_data, .o_phase_a, .o_phase_b, .o_motor_active, .o_idle_mode);
`default_nettype wire

// ==== verification/pdw_piezo_drive_test.sv ====
// testbench: register write sequences checked against measured bridge waveforms
`timescale 1ns/100ps
`default_nettype none
module pdw_piezo_drive_test;
  import pdw_pkg::*;
  logic        i_mclk, i_rst, i_power_down_pin_n, i_wr_en, i_tracking_active, clr;
  logic [7:0]  i_wr_addr, i_wr_data;
  logic [1:0]  o_phase_a, o_phase_b, o_cal_mode;
  logic        o_motor_active, o_idle_mode;
  logic [15:0] pulses, full, per, hi, sh;
  logic [15:0] mix [6] = '{16'h2000, 16'h2020, 16'h2060, 16'h2080, 16'h4080, 16'h1080};
  int          err_total = 0;
  int          cmp_count = 0;
  pdw_piezo_drive uut (.i_mclk, .i_rst, .i_power_down_pin_n, .i_wr_en, .i_wr_addr, .i_wr_data,
    .i_tracking_active, .o_phase_a, .o_phase_b, .o_motor_active, .o_idle_mode, .o_cal_mode);
  pdw_motor_model motor (.i_mclk, .i_clr(clr), .i_a(o_phase_a), .i_b(o_phase_b), .o_pulses(pulses),
    .o_full(full), .o_per(per), .o_hi(hi), .o_sh(sh));
  always #20 i_mclk = ~i_mclk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one byte per strobe; the strobe drops for a clock before the next byte
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    {i_wr_en, i_wr_addr, i_wr_data} = {1'b1, a, d};
    @(negedge i_mclk);
    i_wr_en = 1'b0;
  endtask : wr
  // tallies cleared, then high byte and low byte; the count commits on the low byte
  task automatic go(input logic [7:0] h, input logic [7:0] l);
    clr = 1'b1;
    wr(ADDR_PULSE_HI, h);
    clr = 1'b0;
    wr(ADDR_PULSE_LO, l);
  endtask : go
  // bounded wait for the drive to stop, then time for the legs to settle
  task automatic fin;
    int n;
    for (n = 0; n < 6000 && (n < 3 || o_motor_active !== 1'b0); n++) @(negedge i_mclk);
    if (n >= 6000) err_total++;  // a drive that never stops is a mismatch
    repeat (4) @(negedge i_mclk);
  endtask : fin
  // dead time may eat up to three clocks of the high time
  task automatic near(input logic [15:0] e);
    chk(16'(hi <= e && hi + 16'h0003 >= e), 16'h0001);
  endtask : near
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  // watchdog: the whole sequence needs well under 20000 clocks
  initial begin
    repeat (60000) @(posedge i_mclk);
    err_total++;
    end_of_test();
  end
  initial begin
    {i_mclk, i_rst, i_power_down_pin_n, i_wr_en, i_tracking_active, clr} = 6'h18;
    {i_wr_addr, i_wr_data} = 16'h0000;
    repeat (5) @(negedge i_mclk);
    i_rst = 1'b0;
    wr(ADDR_CONTROL, 8'h63);  // no calibration request, so the offset is live
    go(8'h00, 8'h05);
    fin;
    chk(pulses, 16'h0005);
    chk(per, 16'h007D);
    chk(sh, 16'h001F);
    near(16'h003F);
    wr(ADDR_DUTY, 8'h04);
    wr(ADDR_PHASE, 8'h03);
    wr(ADDR_OFFSET, 8'h02);
    go(8'h40, 8'h03);
    fin;
    chk(per, 16'h007F);
    chk(sh, 16'h007C);
    near(16'h0004);
    i_tracking_active = 1'b1;
    go(8'h00, 8'h03);  // three pulses, so the last two rises are both past dead time
    fin;
    chk(per, 16'h007D);
    i_tracking_active = 1'b0;
    // a sweep calibration request must block the offset as well
    wr(ADDR_CONTROL, 8'h6B);
    go(8'h00, 8'h03);
    fin;
    chk(per, 16'h007D);
    chk(16'(o_cal_mode), 16'h0002);
    wr(ADDR_CONTROL, 8'h63);
    // eight pulses times each ratio is a whole multiple of 128, so the tally is exact
    foreach (mix[i]) begin
      wr(ADDR_OFFSET, mix[i][15:8]);
      wr(ADDR_MIX, mix[i][7:0]);
      go(8'h00, 8'h08);
      fin;
      chk(full, mix[i][15:8] == 8'h40 ? 16'h0000 : 16'(mix[i][7:0] >> 4));
    end
    go(8'h08, 8'h03);
    fin;
    chk(pulses, 16'h0003);
    go(8'h07, 8'hFF);
    repeat (70) @(negedge i_mclk);
    go(8'h00, 8'h00);
    fin;
    chk(16'(pulses < 16'h0002), 16'h0001);
    go(8'h00, 8'hFF);
    repeat (50) @(negedge i_mclk);
    i_power_down_pin_n = 1'b0;
    repeat (3) @(negedge i_mclk);
    chk(16'({o_motor_active, o_phase_a, o_phase_b}), 16'h0000);
    i_power_down_pin_n = 1'b1;
    go(8'h00, 8'h10);
    repeat (300) @(negedge i_mclk);
    wr(ADDR_OFFSET, 8'h80);
    repeat (2) @(negedge i_mclk);
    chk(16'(o_idle_mode), 16'h0001);
    repeat (300) @(negedge i_mclk);
    wr(ADDR_OFFSET, 8'h00);
    fin;
    chk(pulses, 16'h0010);
    near(16'h003F);
    chk(sh, 16'h001F);
    end_of_test();
  end
endmodule : pdw_piezo_drive_test
`default_nettype wire
